// File: design/dea_defines.vh
// Purpose: Constants for the data EEPROM access sequencer
// Assumes: Plain register port, one word per register, 8-bit data
// Notes: Offsets and control bit positions are local choices
//
// Behaviour
// - Page select clear: single byte read
// - Read trigger ignored without read permit
// - Read end loads byte, clears trigger
// - Read byte held until next operation
// - Page select set: page reads, 16 bytes
// - Page read increments address in the cycle the trigger clears
// - Retrigger reads next byte without reload
// - Upper 5 bits fixed, low 4 saturate
// - Page select set: page erase up to 16
// - Page buffer cleared on reset, permit fall
// - Dummy data write tags address, advances
// - Erase timed by timer, trigger self-clears
// - Erase end clears erase permit
// - Erased tagged locations read zero
// - Byte write programs loaded byte, address
// - Write trigger ignored without write permit
// - Write timed, trigger self-clears at end
// - Byte write erases byte first
// - Write end clears write permit
// - Erase or write end sets done flag
`ifndef DEA_DEFINES_VH
`define DEA_DEFINES_VH

`define DEA_OFS_IDX_HIGH 4'h0
`define DEA_OFS_IDX_LOW 4'h1
`define DEA_OFS_BYTE 4'h2
`define DEA_OFS_CTRL 4'h3
`define DEA_OFS_STATUS 4'h4

`define DEA_BIT_FETCH_GO 0
`define DEA_BIT_FETCH_PERMIT 1
`define DEA_BIT_PROG_GO 2
`define DEA_BIT_PROG_PERMIT 3
`define DEA_BIT_PAGE_MODE 4
`define DEA_BIT_WIPE_GO 5
`define DEA_BIT_WIPE_PERMIT 6

`define DEA_RST_BYTE 8'h00
`define DEA_LOW_MAX 4'hf

`define DEA_READ_CYCLES 8
`define DEA_WIPE_CYCLES 2000
`define DEA_PROG_CYCLES 2000
`define DEA_TICK_DIV 4

`endif

// File: design/dea_sequencer.v
// Purpose: Data EEPROM access sequencer with internal cell array
// Assumes: One clock, software on a plain register port
// Notes: Slow timer modelled as divided tick enable
`timescale 1ns/1ps
`default_nettype none
`include "dea_defines.vh"

module dea_sequencer #(
    parameter [11:0] READ_CYCLES = `DEA_READ_CYCLES,
    parameter [11:0] WIPE_TICKS = `DEA_WIPE_CYCLES,
    parameter [11:0] PROG_TICKS = `DEA_PROG_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    output wire nvm_done_flag,
    output wire busy
);

// ------------------------------------------------
// State
// ------------------------------------------------
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_READ = 4'b0010;
localparam [3:0] ST_WIPE = 4'b0100;
localparam [3:0] ST_PROG = 4'b1000;

reg [3:0] state_ff;
reg [11:0] cnt_ff;
reg [1:0] div_ff;
reg [4:0] cell_index_high_ff;
reg [3:0] cell_index_low_ff;
reg [7:0] cell_byte_ff;
reg fetch_go_ff;
reg fetch_permit_ff;
reg prog_go_ff;
reg program_permit_ff;
reg page_mode_ff;
reg wipe_go_ff;
reg wipe_permit_ff;
reg arm_wipe_ff;
reg arm_prog_ff;
reg done_ff;
reg saturated_ff;
reg [15:0] tag_ff;
reg [7:0] rdata_ff;
reg busy_ff;
reg [7:0] mem_ff [0:511];

wire tick = (div_ff == 2'd3);
wire wr_ctrl = reg_wr && (reg_addr == `DEA_OFS_CTRL);
wire wr_byte = reg_wr && (reg_addr == `DEA_OFS_BYTE);
wire wr_low = reg_wr && (reg_addr == `DEA_OFS_IDX_LOW);
wire wr_high = reg_wr && (reg_addr == `DEA_OFS_IDX_HIGH);
wire [8:0] cur_addr = {cell_index_high_ff, cell_index_low_ff};
wire page_tagging = page_mode_ff && !wipe_go_ff && (state_ff == ST_IDLE);

// Low bits advance but stop at the page end
function [3:0] low_step;
    input [3:0] low;
    begin
        low_step = (low == `DEA_LOW_MAX) ? low : low + 4'h1;
    end
endfunction

function [7:0] ctrl_word;
    input dummy;
    begin
        ctrl_word = {1'b0, wipe_permit_ff, wipe_go_ff, page_mode_ff,
                     program_permit_ff, prog_go_ff, fetch_permit_ff, fetch_go_ff};
    end
endfunction

assign reg_rdata = rdata_ff;
assign nvm_done_flag = done_ff;
assign busy = busy_ff;

// ------------------------------------------------
// Slow timer divider
// ------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        div_ff <= 2'd0;
    end else begin
        div_ff <= div_ff + 2'd1;
    end
end

// ------------------------------------------------
// Sequencer
// ------------------------------------------------
integer i;
always @(posedge clk) begin
    if (sys_rst) begin
        state_ff <= ST_IDLE;
        cnt_ff <= 12'd0;
        cell_index_high_ff <= 5'd0;
        cell_index_low_ff <= 4'd0;
        cell_byte_ff <= `DEA_RST_BYTE;
        fetch_go_ff <= 1'b0;
        fetch_permit_ff <= 1'b0;
        prog_go_ff <= 1'b0;
        program_permit_ff <= 1'b0;
        page_mode_ff <= 1'b0;
        wipe_go_ff <= 1'b0;
        wipe_permit_ff <= 1'b0;
        arm_wipe_ff <= 1'b0;
        arm_prog_ff <= 1'b0;
        done_ff <= 1'b0;
        saturated_ff <= 1'b0;
        tag_ff <= 16'h0000;
        busy_ff <= 1'b0;
    end else begin
        // Arm lasts one cycle: trigger must follow permit at once
        arm_wipe_ff <= 1'b0;
        arm_prog_ff <= 1'b0;
        if (reg_rd && reg_addr == `DEA_OFS_STATUS) begin
            done_ff <= 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (wr_high) begin
                    cell_index_high_ff <= reg_wdata[4:0];
                end
                if (wr_low) begin
                    cell_index_low_ff <= reg_wdata[3:0];
                    saturated_ff <= 1'b0;
                end
                if (wr_byte) begin
                    if (page_tagging) begin
                        if (!saturated_ff) begin
                            tag_ff[cell_index_low_ff] <= 1'b1;
                            cell_index_low_ff <= low_step(cell_index_low_ff);
                            saturated_ff <= (cell_index_low_ff == `DEA_LOW_MAX);
                        end
                    end else begin
                        cell_byte_ff <= reg_wdata;
                    end
                end
                if (wr_ctrl) begin
                    page_mode_ff <= reg_wdata[`DEA_BIT_PAGE_MODE];
                    fetch_permit_ff <= reg_wdata[`DEA_BIT_FETCH_PERMIT];
                    wipe_permit_ff <= reg_wdata[`DEA_BIT_WIPE_PERMIT];
                    program_permit_ff <= reg_wdata[`DEA_BIT_PROG_PERMIT];
                    if (wipe_permit_ff && !reg_wdata[`DEA_BIT_WIPE_PERMIT]) begin
                        tag_ff <= 16'h0000;
                    end
                    arm_wipe_ff <= !wipe_permit_ff && reg_wdata[`DEA_BIT_WIPE_PERMIT];
                    arm_prog_ff <= !program_permit_ff &&
                                   reg_wdata[`DEA_BIT_PROG_PERMIT];
                    if (reg_wdata[`DEA_BIT_FETCH_GO] && fetch_permit_ff) begin
                        fetch_go_ff <= 1'b1;
                        state_ff <= ST_READ;
                        busy_ff <= 1'b1;
                        cnt_ff <= READ_CYCLES;
                    end else if (reg_wdata[`DEA_BIT_WIPE_GO] && wipe_permit_ff &&
                                 arm_wipe_ff && page_mode_ff) begin
                        wipe_go_ff <= 1'b1;
                        state_ff <= ST_WIPE;
                        busy_ff <= 1'b1;
                        cnt_ff <= WIPE_TICKS;
                    end else if (reg_wdata[`DEA_BIT_PROG_GO] && program_permit_ff &&
                                 arm_prog_ff && !page_mode_ff) begin
                        prog_go_ff <= 1'b1;
                        state_ff <= ST_PROG;
                        busy_ff <= 1'b1;
                        cnt_ff <= PROG_TICKS;
                        mem_ff[cur_addr] <= 8'h00;
                    end
                end
            end
            ST_READ: begin
                if (cnt_ff <= 12'd1) begin
                    cell_byte_ff <= mem_ff[cur_addr];
                    if (page_mode_ff) begin
                        cell_index_low_ff <= low_step(cell_index_low_ff);
                    end
                    fetch_go_ff <= 1'b0;
                    busy_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end else begin
                    cnt_ff <= cnt_ff - 12'd1;
                end
            end
            ST_WIPE: begin
                if (tick) begin
                    if (cnt_ff <= 12'd1) begin
                        for (i = 0; i < 16; i = i + 1) begin
                            if (tag_ff[i]) begin
                                mem_ff[{cell_index_high_ff, i[3:0]}] <= 8'h00;
                            end
                        end
                        wipe_go_ff <= 1'b0;
                        wipe_permit_ff <= 1'b0;
                        tag_ff <= 16'h0000;
                        done_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 12'd1;
                    end
                end
            end
            ST_PROG: begin
                if (tick) begin
                    if (cnt_ff <= 12'd1) begin
                        mem_ff[cur_addr] <= cell_byte_ff;
                        prog_go_ff <= 1'b0;
                        program_permit_ff <= 1'b0;
                        done_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 12'd1;
                    end
                end
            end
            default: begin
                state_ff <= ST_IDLE;
            end
        endcase
    end
end

// ------------------------------------------------
// Read port
// ------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        rdata_ff <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `DEA_OFS_IDX_HIGH: rdata_ff <= {3'b000, cell_index_high_ff};
            `DEA_OFS_IDX_LOW: rdata_ff <= {4'h0, cell_index_low_ff};
            `DEA_OFS_BYTE: rdata_ff <= cell_byte_ff;
            `DEA_OFS_CTRL: rdata_ff <= ctrl_word(1'b0);
            `DEA_OFS_STATUS: rdata_ff <= {7'h00, done_ff};
            default: rdata_ff <= 8'h00;
        endcase
    end else begin
        rdata_ff <= 8'h00;
    end
end

endmodule // dea_sequencer
`default_nettype wire

// File: test/dea_sequencer_props.sv
// Purpose: Port checker for the EEPROM access sequencer
// Assumes: A status read clears the done flag
// Notes: Bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
`include "dea_defines.vh"
module dea_sequencer_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic nvm_done_flag,
    input wire logic busy
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire sts_rd = reg_rd && reg_addr == `DEA_OFS_STATUS;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_busy_cause; $rose(busy) |-> $past(reg_wr && reg_addr == `DEA_OFS_CTRL); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
    property p_busy_go; $rose(busy) |-> $past(reg_wdata[0] | reg_wdata[2] | reg_wdata[5]); endproperty
    a_busy_go: assert property (p_busy_go) else $error("busy without go bit");
    property p_busy_max; $rose(busy) |-> ##[1:200] !busy; endproperty
    a_busy_max: assert property (p_busy_max) else $error("cycle never ends");
    property p_go_clear; reg_rd && reg_addr == `DEA_OFS_CTRL && !busy |=> (reg_rdata & 8'h25) == 8'h00; endproperty
    a_go_clear: assert property (p_go_clear) else $error("go bit left set");
    property p_done_set; $rose(nvm_done_flag) |-> $past(busy) || $past(busy, 2); endproperty
    a_done_set: assert property (p_done_set) else $error("done without cycle");
    property p_done_hold; $fell(nvm_done_flag) |-> $past(sts_rd) || $past(sts_rd, 2); endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped early");
    property p_done_clr; sts_rd && !busy && !$past(busy) |-> ##2 !nvm_done_flag; endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");
endmodule // dea_sequencer_props
bind dea_sequencer dea_sequencer_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_done_flag(nvm_done_flag), .busy(busy));
`default_nettype wire

// File: test/test_dea_sequencer.sv
// Purpose: Self-checking bench for the EEPROM access sequencer
// Assumes: Short tick counts keep erase and write brief
// Notes: Read results are queued, a monitor checks them
`timescale 1ns/1ps
`default_nettype none
`include "dea_defines.vh"
module test_dea_sequencer;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam logic [3:0] ctl = `DEA_OFS_CTRL;
    localparam logic [3:0] lo_a = `DEA_OFS_IDX_LOW;
    localparam logic [3:0] byt = `DEA_OFS_BYTE;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    wire [7:0] reg_rdata;
    wire nvm_done_flag;
    wire busy;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [7:0] pg[4];
    always #2 clk = ~clk;
    dea_sequencer #(.READ_CYCLES(12'd8), .WIPE_TICKS(12'd3), .PROG_TICKS(12'd3)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nvm_done_flag(nvm_done_flag), .busy(busy));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("TB: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Data stand only one cycle, so the monitor looks exactly then
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[8]) chk(reg_rdata, e[7:0]);
        end
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [8:0] x);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        exp_q.push_back(x);
        @(posedge clk);
    endtask
    task automatic settle();
        int n;
        n = 0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        wr(ctl, 8'h00);
        wr(`DEA_OFS_IDX_HIGH, 8'h0b);
        wr(lo_a, a);
        wr(byt, d);
        wr(ctl, 8'h08);
        wr(ctl, 8'h0c);
        settle();
        chk({7'h00, nvm_done_flag}, 8'h01);
        rd(ctl, 9'h100);
        rd(`DEA_OFS_STATUS, 9'h000);
        settle();
        chk({7'h00, nvm_done_flag}, 8'h00);
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] x);
        wr(ctl, 8'h00);
        wr(lo_a, a);
        wr(ctl, 8'h02);
        wr(ctl, 8'h03);
        settle();
        rd(byt, {1'b1, x});
        rd(ctl, 9'h102);
        settle();
    endtask
    initial begin
        pg[0] = 8'($urandom(86));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        put(8'h03, pg[0]);
        put(8'h03, ~pg[0]);
        get(8'h03, ~pg[0]);
        $display("TB: byte write and read done");
        wr(ctl, 8'h00);
        wr(ctl, 8'h01);
        wr(ctl, 8'h04);
        rd(ctl, 9'h100);
        rd(byt, {1'b1, ~pg[0]});
        wr(ctl, 8'h10);
        wr(ctl, 8'h50);
        settle();
        wr(ctl, 8'h70);
        rd(ctl, 9'h150);
        wr(ctl, 8'h10);
        settle();
        $display("TB: refusals done");
        for (int i = 0; i < 4; i++) begin
            pg[i] = 8'($urandom) | 8'h01;
            put(8'h0c + i[7:0], pg[i]);
        end
        // Early tag is dropped by the permit fall, so its byte survives
        wr(ctl, 8'h10);
        wr(lo_a, 8'h0c);
        wr(byt, 8'h5a);
        wr(ctl, 8'h50);
        wr(ctl, 8'h10);
        repeat (4) wr(byt, 8'h5a);
        rd(lo_a, 9'h10f);
        wr(ctl, 8'h50);
        wr(ctl, 8'h70);
        settle();
        chk({7'h00, nvm_done_flag}, 8'h01);
        rd(ctl, 9'h110);
        rd(`DEA_OFS_STATUS, 9'h000);
        wr(lo_a, 8'h0c);
        wr(ctl, 8'h12);
        for (int i = 0; i < 5; i++) begin
            wr(ctl, 8'h13);
            settle();
            rd(byt, {1'b1, (i == 0) ? pg[0] : 8'h00});
        end
        rd(lo_a, 9'h10f);
        rd(`DEA_OFS_IDX_HIGH, 9'h10b);
        settle();
        $display("TB: page erase and read done");
        end_of_test();
    end
endmodule // test_dea_sequencer
`default_nettype wire
